// File: src/sbs_pkg.sv
/*
  Package for the sensor bias and system control register block.
  Assumes one clock domain and an APB slave with 32-bit data.
*/
package sbs_pkg;
  // ************************************************************
  // Register map (register indices and byte addresses)
  // ************************************************************
  localparam logic [7:0] SENSOR_BIAS_SELECT_IDX = 8'h08;
  localparam logic [7:0] SYSTEM_CONTROL_IDX = 8'h09;
  localparam logic [11:0] SENSOR_BIAS_SELECT_ADDR = {2'h0, SENSOR_BIAS_SELECT_IDX, 2'h0};
  localparam logic [11:0] SYSTEM_CONTROL_ADDR = {2'h0, SYSTEM_CONTROL_IDX, 2'h0};
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] SENSOR_BIAS_SELECT_RST = 8'h00;
  localparam logic [7:0] SYSTEM_CONTROL_RST = 8'h10;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIAS_LEVEL_BIT = 7;
  localparam int BIAS_COMMON_BIT = 6;
  localparam int BIAS_INPUT_HI = 5;
  localparam int MON_HI = 7;
  localparam int MON_LO = 5;
  localparam int CAL_HI = 4;
  localparam int CAL_LO = 3;
  localparam int TIMEOUT_BIT = 2;
  localparam int CHECK_BYTE_BIT = 1;
  localparam int STATUS_BYTE_BIT = 0;
  // ************************************************************
  // Monitor codes and amplifier enable code
  // ************************************************************
  localparam logic [2:0] MON_OFF = 3'h0;
  localparam logic [2:0] MON_MID_SUPPLY = 3'h1;
  localparam logic [2:0] MON_TEMP = 3'h2;
  localparam logic [2:0] MON_ANALOG_SUPPLY = 3'h3;
  localparam logic [2:0] MON_DIGITAL_SUPPLY = 3'h4;
  localparam logic [2:0] MON_BURNOUT_LOW = 3'h5;
  localparam logic [2:0] MON_BURNOUT_MID = 3'h6;
  localparam logic [2:0] MON_BURNOUT_HIGH = 3'h7;
  localparam logic [1:0] AMP_ENABLED = 2'h1;
endpackage

// File: src/sbs_regs.sv
/*
  Sensor bias and system control registers with decoded analog controls.
  Assumes an APB master on the same clock; analog circuits and the serial
  readout logic sit outside and consume the decoded outputs.
*/
// The APB register port was left to the implementer.
// Behaviour
// - Bit 7 picks half or twelfth bias
// - Bias generator on only if connected
// - Bits 0-5 connect bias to inputs
// - Bit 6 connects bias to common input
// - Any bias connect combination allowed together
// - Monitor 000 off, 001 mid-supply short
// - Monitor 010 temperature, needs amplifier enabled
// - Supply monitors force amplifier gain one
// - Codes 101-111 select burn-out currents
// - Bits 4:3 pick calibration average count
// - System control at 09h, reset 10h
// - Check byte enable appends CRC
// - Status byte enable prepends status byte
// - Internal monitors open input multiplexer
`timescale 1ns/100ps
module sbs_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Amplifier state from the gain register block
  input wire logic [1:0] amplifier_enable_field,
  // Bias controls
  output logic bias_level_select,
  output logic bias_generator_enable,
  output logic [5:0] bias_to_input,
  output logic bias_to_common_input,
  // Monitor controls
  output logic [2:0] monitor_select,
  output logic mid_supply_short,
  output logic temp_sensor_select,
  output logic temp_sensor_misconfigured,
  output logic analog_supply_monitor,
  output logic digital_supply_monitor,
  output logic force_unity_gain,
  output logic [2:0] burnout_current_select,
  output logic input_mux_open,
  // Calibration and interface options
  output logic [4:0] calibration_average_count,
  output logic spi_timeout_enable,
  output logic check_byte_enable,
  output logic status_byte_enable
);
  // ************************************************************
  // Register storage
  // ************************************************************
  logic [7:0] sensor_bias_select;
  logic [7:0] system_control;
  logic [31:0] prdata_q;

  wire access = psel && penable;
  wire hit_bias = paddr == sbs_pkg::SENSOR_BIAS_SELECT_ADDR;
  wire hit_sys = paddr == sbs_pkg::SYSTEM_CONTROL_ADDR;
  wire mapped = hit_bias || hit_sys;
  // Only the low byte lane holds data; upper lanes are ignored
  wire wr_bias = access && pwrite && hit_bias && pstrb[0];
  wire wr_sys = access && pwrite && hit_sys && pstrb[0];
  wire [7:0] rd_byte = hit_bias ? sensor_bias_select : (hit_sys ? system_control : 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sensor_bias_select <= sbs_pkg::SENSOR_BIAS_SELECT_RST;
    end else if (wr_bias) begin
      sensor_bias_select <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_control <= sbs_pkg::SYSTEM_CONTROL_RST;
    end else if (wr_sys) begin
      system_control <= pwdata[7:0];
    end
  end

  // Read data is registered during setup so it is stable in the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  // ************************************************************
  // Bias decode
  // ************************************************************
  assign bias_level_select = sensor_bias_select[sbs_pkg::BIAS_LEVEL_BIT];
  assign bias_to_input = sensor_bias_select[sbs_pkg::BIAS_INPUT_HI:0];
  assign bias_to_common_input = sensor_bias_select[sbs_pkg::BIAS_COMMON_BIT];
  // Saves bias generator power when nothing would use it
  assign bias_generator_enable = |sensor_bias_select[sbs_pkg::BIAS_COMMON_BIT:0];

  // ************************************************************
  // Monitor decode
  // ************************************************************
  assign monitor_select = system_control[sbs_pkg::MON_HI:sbs_pkg::MON_LO];
  assign mid_supply_short = monitor_select == sbs_pkg::MON_MID_SUPPLY;
  assign temp_sensor_select = monitor_select == sbs_pkg::MON_TEMP;
  // Flags a software slip; hardware cannot enable the amplifier itself
  assign temp_sensor_misconfigured = temp_sensor_select
                                     && (amplifier_enable_field != sbs_pkg::AMP_ENABLED);
  assign analog_supply_monitor = monitor_select == sbs_pkg::MON_ANALOG_SUPPLY;
  assign digital_supply_monitor = monitor_select == sbs_pkg::MON_DIGITAL_SUPPLY;
  assign force_unity_gain = analog_supply_monitor || digital_supply_monitor;
  assign burnout_current_select = {monitor_select == sbs_pkg::MON_BURNOUT_HIGH,
                                   monitor_select == sbs_pkg::MON_BURNOUT_MID,
                                   monitor_select == sbs_pkg::MON_BURNOUT_LOW};
  assign input_mux_open = mid_supply_short || temp_sensor_select || force_unity_gain;

  // ************************************************************
  // Calibration and interface options
  // ************************************************************
  wire [1:0] cal_code = system_control[sbs_pkg::CAL_HI:sbs_pkg::CAL_LO];
  assign calibration_average_count = (cal_code == 2'h0) ? 5'h01 :
                                     (cal_code == 2'h1) ? 5'h04 :
                                     (cal_code == 2'h2) ? 5'h08 : 5'h10;
  assign spi_timeout_enable = system_control[sbs_pkg::TIMEOUT_BIT];
  assign check_byte_enable = system_control[sbs_pkg::CHECK_BYTE_BIT];
  assign status_byte_enable = system_control[sbs_pkg::STATUS_BYTE_BIT];
endmodule

// File: verification/sbs_regs_checker.sv
/* Port assertions for the bias and system control registers.
   Assumes one clock and the APB map of sbs_pkg. */
`timescale 1ns/100ps
module sbs_regs_checker (
  // Clock, reset and APB
  input wire logic clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Decoded controls
  input wire logic [1:0] amplifier_enable_field,
  input wire logic bias_level_select, bias_generator_enable, bias_to_common_input, temp_sensor_select,
  input wire logic temp_sensor_misconfigured, force_unity_gain, input_mux_open,
  input wire logic spi_timeout_enable, check_byte_enable, status_byte_enable,
  input wire logic [5:0] bias_to_input,
  input wire logic [2:0] monitor_select, burnout_current_select,
  input wire logic [4:0] calibration_average_count
);
  // ****************************************
  // Write strobes
  // ****************************************
  wire logic acc = psel && penable && pready;
  wire logic wb = acc && pwrite && pstrb[0] && paddr == sbs_pkg::SENSOR_BIAS_SELECT_ADDR;
  wire logic ws = acc && pwrite && pstrb[0] && paddr == sbs_pkg::SYSTEM_CONTROL_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_level_sel: assert property (wb |=> bias_level_select == $past(pwdata[7])) else $error("level bit");
  a_gen_on: assert property (bias_generator_enable == |{bias_to_common_input, bias_to_input}) else $error("gen");
  a_bias_conn: assert property (wb |=> {bias_to_common_input, bias_to_input} == $past(pwdata[6:0]))
    else $error("bias connect");
  a_mon_write: assert property (ws |=> monitor_select == $past(pwdata[7:5])) else $error("monitor field");
  a_temp_flag: assert property (temp_sensor_misconfigured == (temp_sensor_select && amplifier_enable_field != 2'h1))
    else $error("temp flag");
  a_unity_gain: assert property (force_unity_gain == (monitor_select inside {3'h3, 3'h4})) else $error("gain");
  a_burn_out: assert property (burnout_current_select == {monitor_select == 3'h7, monitor_select == 3'h6,
    monitor_select == 3'h5}) else $error("burn-out");
  a_cal_count: assert property (ws |=> calibration_average_count ==
    ($past(pwdata[4:3]) == 2'h0 ? 5'h01 : 5'h02 << $past(pwdata[4:3]))) else $error("cal count");
  a_opt_bits: assert property (ws |=> {spi_timeout_enable, check_byte_enable, status_byte_enable} == $past(pwdata[2:0]))
    else $error("option bits");
  a_mux_open: assert property (input_mux_open == (monitor_select inside {[3'h1:3'h4]})) else $error("mux");
  a_reset_dflt: assert property ($rose(rst_n) |-> monitor_select == 3'h0 && calibration_average_count == 5'h08)
    else $error("reset value");
  c_temp_bad: cover property (ws ##1 temp_sensor_misconfigured);
  c_bias_on: cover property (wb ##1 bias_generator_enable);
  c_refused: cover property (acc && pslverr);
endmodule
bind sbs_regs sbs_regs_checker u_sbs_regs_checker (.clk, .rst_n, .psel, .penable, .pwrite, .pready, .pslverr,
  .paddr, .pwdata, .pstrb, .amplifier_enable_field, .bias_level_select, .bias_generator_enable,
  .bias_to_common_input, .temp_sensor_select, .temp_sensor_misconfigured, .force_unity_gain, .input_mux_open,
  .spi_timeout_enable, .check_byte_enable, .status_byte_enable, .bias_to_input, .monitor_select,
  .burnout_current_select, .calibration_average_count);

// File: verification/testbench.sv
/* Self-checking bench for sbs_regs.
   Drives APB and the amplifier field; the checker is bound to the design. */
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] amplifier_enable_field = 2'h1;
  logic pready, pslverr, bias_level_select, bias_generator_enable, bias_to_common_input, mid_supply_short;
  logic temp_sensor_select, temp_sensor_misconfigured, analog_supply_monitor, digital_supply_monitor;
  logic force_unity_gain, input_mux_open, spi_timeout_enable, check_byte_enable, status_byte_enable;
  logic [5:0] bias_to_input;
  logic [2:0] monitor_select, burnout_current_select;
  logic [4:0] calibration_average_count;
  int err_count = 0, checks = 0, cyc = 0;
  // Rows: address, write data, expected read-back
  logic [27:0] rows [11] = '{28'h0208080, 28'h0207F7F, 28'h0202A2A, 28'h0240000, 28'h0243B3B, 28'h0244040,
    28'h0246C6C, 28'h0249494, 28'h024B8B8, 28'h024C1C1, 28'h024E7E7};
  sbs_regs u_sbs_regs (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .amplifier_enable_field, .bias_level_select, .bias_generator_enable, .bias_to_input, .bias_to_common_input,
    .monitor_select, .mid_supply_short, .temp_sensor_select, .temp_sensor_misconfigured, .analog_supply_monitor,
    .digital_supply_monitor, .force_unity_gain, .burnout_current_select, .input_mux_open,
    .calibration_average_count, .spi_timeout_enable, .check_byte_enable, .status_byte_enable);
  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Request held until pready is seen high; released only after that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, 12'h020, 32'h0, 4'h0);
    chk("bias reset", 32'h0, rd);
    chk("mapped no error", 32'h0, slv);
    apb(1'h0, 12'h024, 32'h0, 4'h0);
    chk("sys reset", 32'h10, rd);
    chk("cal reset", 32'h8, calibration_average_count);
    foreach (rows[i]) begin
      apb(1'h1, rows[i][27:16], rows[i][15:8], 4'h1);
      apb(1'h0, rows[i][27:16], 32'h0, 4'h0);
      chk("readback", rows[i][7:0], rd);
    end
    chk("options", 32'h7, {spi_timeout_enable, check_byte_enable, status_byte_enable});
    chk("bias gen", 32'h1, bias_generator_enable);
    apb(1'h1, 12'h024, 32'h20, 4'h0);
    apb(1'h0, 12'h024, 32'h0, 4'h0);
    chk("strobe off", 32'hE7, rd);
    // Every monitor code, decoded outputs checked one cycle after the write lands
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, 12'h024, {24'h00_0000, k[2:0], 5'h10}, 4'h1);
      @(posedge clk);
      chk("monitor decode", {k == 1, k == 2, k == 3, k == 4, k == 3 || k == 4, k >= 1 && k <= 4, k == 7, k == 6, k == 5},
        {mid_supply_short, temp_sensor_select, analog_supply_monitor, digital_supply_monitor, force_unity_gain,
        input_mux_open, burnout_current_select});
    end
    apb(1'h0, 12'h028, 32'h0, 4'h0);
    chk("unmapped err", 32'h1, slv);
    chk("unmapped data", 32'h0, rd);
    amplifier_enable_field <= 2'h0;
    apb(1'h1, 12'h024, 32'h40, 4'h1);
    @(posedge clk);
    chk("temp bad", 32'h1, temp_sensor_misconfigured);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, 12'h024, 32'h0, 4'h0);
    chk("sys re-reset", 32'h10, rd);
    print_verdict();
  end
endmodule
